// >>> hdl/auart_top.sv
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`include "auart_map.svh"

module auart_top
  import auart_pkg::*;
(
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        reset,
  // Avalon-MM register slave.
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Mode, clear and 16x bit clocks.
  input  wire logic        mode_sel,
  input  wire logic        master_clear,
  input  wire logic        rx_clk16,
  input  wire logic        tx_clk16,
  // Serial line.
  input  wire logic        serial_in,
  output logic             serial_out,
  // Parallel buses.
  input  wire logic [7:0]  tx_bus,
  output logic      [7:0]  rx_bus_o,
  output logic             rx_bus_oe,
  // Pin-mode controls.
  input  wire logic        rx_bus_disable,
  input  wire logic        flag_output_disable,
  input  wire logic        rx_ready_clear_n,
  input  wire logic        tx_hold_load_n,
  input  wire logic        config_load,
  input  wire auart_ctrl_type cfg_pins,
  // Processor bus mode controls.
  input  wire logic        reg_select,
  input  wire logic        rd_not_wr,
  input  wire logic        chip_sel_a,
  input  wire logic        chip_sel_b,
  input  wire logic        chip_sel_c,
  input  wire logic        bus_write_strobe,
  // Flag outputs.
  output auart_flags_type  flags_o,
  output logic             flags_oe,
  output logic             tx_shift_empty
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Returns the last data bit index for the selected length.
  // length decode
  function automatic logic [2:0] last_bit(input auart_ctrl_type c);
    last_bit = 3'h4 + {1'b0, c.length_sel_hi, c.length_sel_lo};
  endfunction

  // Masks a character down to the selected length.
  function automatic logic [7:0] mask_len(input logic [7:0] d,
                                          input auart_ctrl_type c);
    mask_len = d & (8'hFF >> (3'h7 - last_bit(c)));
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  auart_ctrl_type  ctrl_r;
  auart_state_type tst_r, rst_r;
  logic [7:0]      thr_r, tsr_r, rhr_r, rsr_r, rx_bus_r;
  logic [4:0]      tcnt_r;
  logic [3:0]      rcnt_r;
  logic [2:0]      tbit_r, rbit_r;
  logic            thr_full_r, tpar_r, so_r, tx_shift_empty_r, rpar_r, rprev_r;
  logic            ready_r, ovr_r, pe_r, fe_r, rclk_d_r, tclk_d_r;
  logic            load_low_r, strobe_wr_r, ack_r;
  logic [31:0]     rdata_r;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------

  // Clear covers both the system reset and the master clear pin.
  wire logic clr = reset | master_clear;
  wire logic rx_tick = rx_clk16 & ~rclk_d_r;
  wire logic tx_tick = tx_clk16 & ~tclk_d_r;
  wire logic avs_req  = (avs_read | avs_write) & ~ack_r;
  wire logic avs_wr   = avs_write & avs_req;
  wire logic avs_rd   = avs_read & avs_req;
  wire logic chip_sel = chip_sel_a & chip_sel_b & chip_sel_c;
  wire logic strobe_wr = bus_write_strobe & chip_sel & ~rd_not_wr;
  wire logic mode_pin = ~mode_sel;
  wire logic pin_thr_ld = mode_pin & load_low_r & tx_hold_load_n;
  wire logic bus_wr_end = mode_sel & strobe_wr_r & ~bus_write_strobe;
  wire logic bus_thr_ld = bus_wr_end & ~reg_select;
  wire logic bus_ctrl_ld = bus_wr_end & reg_select;
  wire logic bus_rd = mode_sel & chip_sel & rd_not_wr;
  wire logic avs_thr_ld = avs_wr & (avs_address == `AUART_OFS_TXHOLD);
  wire logic avs_ctrl_ld = avs_wr & (avs_address == `AUART_OFS_CTRL);
  wire logic avs_rhr_rd = avs_rd & (avs_address == `AUART_OFS_RXHOLD);
  wire logic thr_load = pin_thr_ld | bus_thr_ld | avs_thr_ld;
  wire logic [7:0] thr_data = avs_thr_ld ? avs_writedata[7:0] : tx_bus;
  wire logic pin_ctrl_ld = mode_pin & config_load;
  wire auart_ctrl_type bus_ctrl = avs_ctrl_ld ? avs_writedata[4:0]
                                              : tx_bus[4:0];
  // Status byte shared by Avalon reads and the mode 1 bus.
  wire logic [7:0] status = {2'b00, tx_shift_empty_r, ~thr_full_r, fe_r, pe_r,
                             ovr_r, ready_r};
  // Avalon read mux; unmapped offsets read as zero.
  wire logic [7:0] avs_mux =
    (avs_address == `AUART_OFS_CTRL)   ? {3'b000, ctrl_r} :
    (avs_address == `AUART_OFS_RXHOLD) ? rhr_r :
    (avs_address == `AUART_OFS_STATUS) ? status : `AUART_BYTE_RESET;
  // Transmit frame timing.
  wire logic tbit_end = (tcnt_r[3:0] == `AUART_BIT_LAST);
  wire logic [4:0] stop_last =
    ~ctrl_r.stop_count_select ? `AUART_STOP1_LAST :
    (last_bit(ctrl_r) == 3'h4) ? `AUART_STOP15_LAST : `AUART_STOP2_LAST;
  wire logic tx_par = ^mask_len(thr_r, ctrl_r) ^ ~ctrl_r.parity_even_select;
  wire logic rx_mismatch = ^rsr_r ^ rpar_r ^ ~ctrl_r.parity_even_select;
  wire logic rbit_end = (rcnt_r == `AUART_BIT_LAST);
  wire logic ready_clr = ~rx_ready_clear_n | avs_rhr_rd;

  // ----------------------------------------------------------------
  // Bus and pin edge tracking
  // ----------------------------------------------------------------

  // Edge history of clocks, strobes and the Avalon handshake.
  always_ff @(posedge mclk) begin
    if (reset) begin
      rclk_d_r    <= 1'b0;
      tclk_d_r    <= 1'b0;
      load_low_r  <= 1'b0;
      strobe_wr_r <= 1'b0;
      ack_r       <= 1'b0;
      rdata_r     <= 32'h0000_0000;
    end else begin
      rclk_d_r    <= rx_clk16;
      tclk_d_r    <= tx_clk16;
      load_low_r  <= ~tx_hold_load_n;
      strobe_wr_r <= strobe_wr;
      ack_r       <= avs_req;
      if (avs_rd) begin
        rdata_r <= {24'h00_0000, avs_mux};
      end
    end
  end
  // Control register load from pins, mode 1 bus or Avalon.
  always_ff @(posedge mclk) begin
    if (clr) begin
      ctrl_r <= `AUART_CTRL_RESET;
    end else if (pin_ctrl_ld) begin
      ctrl_r <= cfg_pins;
    end else if (bus_ctrl_ld | avs_ctrl_ld) begin
      ctrl_r <= bus_ctrl;
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------

  // Holding register; a new load wins over a same-cycle transfer.
  always_ff @(posedge mclk) begin
    if (clr) begin
      thr_r      <= `AUART_BYTE_RESET;
      thr_full_r <= 1'b0;
    end else if (thr_load) begin
      thr_r      <= thr_data;
      thr_full_r <= 1'b1;
    end else if (tx_tick & thr_full_r & ((tst_r == AUART_IDLE) |
                 ((tst_r == AUART_STOP) & (tcnt_r == stop_last)))) begin
      thr_full_r <= 1'b0;
    end
  end

  // Frame sequencer, advanced on each transmit clock tick.
  always_ff @(posedge mclk) begin
    if (clr) begin
      so_r   <= 1'b1;
      tx_shift_empty_r <= 1'b1;
      tst_r  <= AUART_IDLE;
      tcnt_r <= 5'h00;
      tbit_r <= 3'h0;
      tsr_r  <= `AUART_BYTE_RESET;
      tpar_r <= 1'b0;
    end else if (tx_tick) begin
      tcnt_r <= tcnt_r + 5'h01;
      case (tst_r)
        AUART_IDLE, AUART_STOP: begin
          if ((tst_r == AUART_IDLE) | (tcnt_r == stop_last)) begin
            tcnt_r <= 5'h00;
            if (thr_full_r) begin
              so_r   <= 1'b0;
              tx_shift_empty_r <= 1'b0;
              tsr_r  <= thr_r;
              tpar_r <= tx_par;
              tst_r  <= AUART_START;
            end else begin
              tx_shift_empty_r <= 1'b1;
              tst_r  <= AUART_IDLE;
            end
          end
        end
        AUART_START: begin
          if (tbit_end) begin
            tcnt_r <= 5'h00;
            so_r   <= tsr_r[0];
            tsr_r  <= tsr_r >> 1;
            tbit_r <= 3'h0;
            tst_r  <= AUART_DATA;
          end
        end
        AUART_DATA: begin
          if (tbit_end) begin
            tcnt_r <= 5'h00;
            if (tbit_r == last_bit(ctrl_r)) begin
              so_r  <= ctrl_r.parity_inhibit ? 1'b1 : tpar_r;
              tst_r <= ctrl_r.parity_inhibit ? AUART_STOP : AUART_PARITY;
            end else begin
              so_r   <= tsr_r[0];
              tsr_r  <= tsr_r >> 1;
              tbit_r <= tbit_r + 3'h1;
            end
          end
        end
        AUART_PARITY: begin
          if (tbit_end) begin
            tcnt_r <= 5'h00;
            so_r   <= 1'b1;
            tst_r  <= AUART_STOP;
          end
        end
        default: begin
          tst_r <= AUART_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------

  // Frame sequencer, sampled on each receive clock tick.
  always_ff @(posedge mclk) begin
    if (clr) begin
      rst_r   <= AUART_IDLE;
      rcnt_r  <= 4'h0;
      rbit_r  <= 3'h0;
      rsr_r   <= `AUART_BYTE_RESET;
      rpar_r  <= 1'b0;
      rprev_r <= 1'b1;
    end else if (rx_tick) begin
      rcnt_r <= rcnt_r + 4'h1;
      case (rst_r)
        AUART_IDLE: begin
          rprev_r <= serial_in;
          rcnt_r  <= 4'h0;
          if (rprev_r & ~serial_in) begin
            rst_r <= AUART_START;
            rsr_r <= `AUART_BYTE_RESET;
          end
        end
        AUART_START: begin
          if (rcnt_r == `AUART_START_CHECK) begin
            rcnt_r <= 4'h0;
            rbit_r <= 3'h0;
            rst_r  <= serial_in ? AUART_IDLE : AUART_DATA;
          end
        end
        AUART_DATA: begin
          if (rbit_end) begin
            rsr_r <= rsr_r >> 1;
            rsr_r[last_bit(ctrl_r)] <= serial_in;
            rbit_r <= rbit_r + 3'h1;
            if (rbit_r == last_bit(ctrl_r)) begin
              rst_r <= ctrl_r.parity_inhibit ? AUART_STOP : AUART_PARITY;
            end
          end
        end
        AUART_PARITY: begin
          if (rbit_end) begin
            rpar_r <= serial_in;
            rst_r  <= AUART_STOP;
          end
        end
        AUART_STOP: begin
          if (rbit_end) begin
            rprev_r <= serial_in;
            rst_r   <= AUART_IDLE;
          end
        end
        default: begin
          rst_r <= AUART_IDLE;
        end
      endcase
    end
  end

  // Holding register and flags, updated at the first stop midpoint.
  wire logic rx_xfer = rx_tick & (rst_r == AUART_STOP) & rbit_end;
  always_ff @(posedge mclk) begin
    if (clr) begin
      rhr_r   <= `AUART_BYTE_RESET;
      ready_r <= 1'b0;
      ovr_r   <= 1'b0;
      pe_r    <= 1'b0;
      fe_r    <= 1'b0;
    end else if (rx_xfer) begin
      rhr_r   <= rsr_r;
      ready_r <= 1'b1;
      ovr_r   <= ready_r & ~ready_clr;
      pe_r    <= ~ctrl_r.parity_inhibit & rx_mismatch;
      fe_r    <= ~serial_in;
    end else if (ready_clr) begin
      ready_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Receive bus data: status in mode 1 when selected, else holding reg.
  always_ff @(posedge mclk) begin
    if (reset) begin
      rx_bus_r <= `AUART_BYTE_RESET;
    end else begin
      rx_bus_r <= (bus_rd & reg_select) ? status : rhr_r;
    end
  end

  assign rx_bus_oe = ~rx_bus_disable & (mode_pin | bus_rd);
  assign rx_bus_o  = rx_bus_r;
  assign flags_oe  = ~flag_output_disable;
  assign flags_o   = '{tx_hold_empty: ~thr_full_r, rx_char_ready: ready_r,
                       overrun_fault: ovr_r, stop_fault: fe_r,
                       parity_fault: pe_r};
  assign tx_shift_empty  = tx_shift_empty_r;
  assign serial_out      = so_r;
  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = avs_req;
endmodule

// >>> hdl/auart_map.svh
`ifndef AUART_MAP_SVH
`define AUART_MAP_SVH

// Register byte offsets on the Avalon-MM slave.
`define AUART_OFS_CTRL    4'h0
`define AUART_OFS_TXHOLD  4'h4
`define AUART_OFS_RXHOLD  4'h8
`define AUART_OFS_STATUS  4'hC

// Control register fields.
`define AUART_CTRL_LEN_LO   0
`define AUART_CTRL_LEN_HI   1
`define AUART_CTRL_STOP     2
`define AUART_CTRL_EVEN     3
`define AUART_CTRL_INHIBIT  4

// Status register fields.
`define AUART_ST_READY      0
`define AUART_ST_OVERRUN    1
`define AUART_ST_PARITY     2
`define AUART_ST_STOP       3
`define AUART_ST_THR_EMPTY  4
`define AUART_ST_TSR_EMPTY  5

// Reset values.
`define AUART_CTRL_RESET    5'h00
`define AUART_BYTE_RESET    8'h00

// Timing counts in ticks of the 16x bit clocks.
`define AUART_START_CHECK   4'h7
`define AUART_BIT_LAST      4'hF
`define AUART_STOP1_LAST    5'h0F
`define AUART_STOP15_LAST   5'h17
`define AUART_STOP2_LAST    5'h1F

`endif

// >>> hdl/auart_pkg.sv
package auart_pkg;

  // Format latched in the control register.
  typedef struct packed {
    logic parity_inhibit;
    logic parity_even_select;
    logic stop_count_select;
    logic length_sel_hi;
    logic length_sel_lo;
  } auart_ctrl_type;

  // Status and error flags brought out on pins.
  typedef struct packed {
    logic tx_hold_empty;
    logic rx_char_ready;
    logic overrun_fault;
    logic stop_fault;
    logic parity_fault;
  } auart_flags_type;

  // Serial frame sequencer states, Gray coded along the frame.
  typedef enum logic [2:0] {
    AUART_IDLE   = 3'h0,
    AUART_START  = 3'h1,
    AUART_DATA   = 3'h3,
    AUART_PARITY = 3'h2,
    AUART_STOP   = 3'h6
  } auart_state_type;

endpackage

// >>> testbench/auart_chk.sv
module auart_chk
  import auart_pkg::*;
(
  // Clock and reset.
  input wire logic            mclk,
  input wire logic            reset,
  // Register slave.
  input wire logic [3:0]      avs_address,
  input wire logic            avs_read,
  input wire logic            avs_write,
  input wire logic [31:0]     avs_readdata,
  input wire logic            avs_waitrequest,
  // Pins watched.
  input wire logic            mode_sel,
  input wire logic            master_clear,
  input wire logic            serial_out,
  input wire logic            rx_bus_oe,
  input wire logic            rx_bus_disable,
  input wire logic            flag_output_disable,
  input wire logic            rx_ready_clear_n,
  input wire logic            rd_not_wr,
  input wire auart_flags_type flags_o,
  input wire logic            flags_oe,
  input wire logic            tx_shift_empty
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  // Flag enable tracks its disable pin; receive bus enable does in pin mode and stays off on mode 1 writes.
  a_flag_float: assert property (flags_oe == !flag_output_disable)
    else $error("flag enable wrong");
  a_rxbus_pin: assert property (!mode_sel |-> rx_bus_oe == !rx_bus_disable)
    else $error("receive bus enable wrong");
  a_rxbus_write: assert property (mode_sel && !rd_not_wr |-> !rx_bus_oe)
    else $error("receive bus driven on write");

  // Master clear idles the line and the flags.
  a_clear_line: assert property (master_clear |=> serial_out
    && tx_shift_empty && flags_o.tx_hold_empty && !flags_o.rx_char_ready)
    else $error("master clear state wrong");

  // The slave waits exactly one cycle; holes read as zero.
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest)
    else $error("wait state count wrong");
  a_hole_zero: assert property (avs_read && avs_waitrequest
    && avs_address[1:0] != 2'h0 |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");

  // Low serial levels last at least eight system cycles; start ends idle.
  a_start_hold: assert property ($fell(serial_out) |-> !serial_out [*8])
    else $error("serial bit too short");
  a_busy_start: assert property (!serial_out |-> ##[0:1] !tx_shift_empty)
    else $error("shift empty during frame");

  // A held clear drops the ready flag unless a new character lands.
  a_ready_clear: assert property ((!rx_ready_clear_n) [*3] |=>
    !flags_o.rx_char_ready || !$past(flags_o.rx_char_ready))
    else $error("ready not cleared");

  c_tx_frame: cover property ($fell(serial_out));
  c_rx_char: cover property ($rose(flags_o.rx_char_ready));
  c_overrun: cover property ($rose(flags_o.overrun_fault));
endmodule

bind auart_top auart_chk i_chk (.mclk, .reset, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .mode_sel, .master_clear,
  .serial_out, .rx_bus_oe, .rx_bus_disable, .flag_output_disable,
  .rx_ready_clear_n, .rd_not_wr, .flags_o, .flags_oe, .tx_shift_empty);

// >>> testbench/auart_far.sv
module auart_far (
  // Clock and 16x tick.
  input  wire logic        mclk,
  input  wire logic        tick,
  // Frame request, bit 0 sent first.
  input  wire logic        go,
  input  wire logic [11:0] frame,
  input  wire logic [3:0]  nbits,
  // Line toward the receiver.
  output logic             line,
  output logic             busy
);
  timeunit 1ns;
  timeprecision 1ps;

  logic        tick_q = 1'b0;
  logic [7:0]  cnt    = 8'h00;
  logic [11:0] sh     = 12'hFFF;

  // idle high, sixteen ticks per bit.
  assign line = busy ? sh[0] : 1'b1;
  initial busy = 1'b0;

  // Each bit stands for sixteen rising ticks of the bit clock.
  always @(posedge mclk) begin
    tick_q <= tick;
    if (go) begin
      sh   <= frame;
      cnt  <= {nbits, 4'h0};
      busy <= 1'b1;
    end else if (busy && tick && !tick_q) begin
      cnt <= cnt - 8'h01;
      if (cnt[3:0] == 4'h1) sh <= {1'b1, sh[11:1]};
      if (cnt == 8'h01) busy <= 1'b0;
    end
  end
endmodule

// >>> testbench/test_auart_top.sv
module test_auart_top
  import auart_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic avs_waitrequest, serial_in, serial_out, rx_bus_oe, flags_oe;
  logic mode_sel = 1'b0, master_clear = 1'b0, go = 1'b0, far_busy;
  logic rx_clk16 = 1'b0, tx_clk16 = 1'b0, tx_shift_empty;
  logic [7:0] tx_bus = 8'h00, rx_bus_o, d;
  logic rx_bus_disable = 1'b0, flag_output_disable = 1'b0;
  logic rx_ready_clear_n = 1'b1, tx_hold_load_n = 1'b1, config_load = 1'b0;
  logic reg_select = 1'b0, rd_not_wr = 1'b0, bus_write_strobe = 1'b0;
  logic chip_sel_a = 1'b0, chip_sel_b = 1'b0, chip_sel_c = 1'b0;
  logic [11:0] frame = 12'hFFF;
  logic [3:0] nbits = 4'h0;
  logic [1:0] tick_cnt = 2'h0;
  auart_ctrl_type cfg_pins = 5'h00, cfg, c;
  auart_flags_type flags_o;
  int fails = 0, num_checks = 0, i;

  auart_top i_dut (.mclk, .reset, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .mode_sel,
    .master_clear, .rx_clk16, .tx_clk16, .serial_in, .serial_out, .tx_bus,
    .rx_bus_o, .rx_bus_oe, .rx_bus_disable, .flag_output_disable,
    .rx_ready_clear_n, .tx_hold_load_n, .config_load, .cfg_pins,
    .reg_select, .rd_not_wr, .chip_sel_a, .chip_sel_b, .chip_sel_c,
    .bus_write_strobe, .flags_o, .flags_oe, .tx_shift_empty);
  auart_far i_far (.mclk, .tick(rx_clk16), .go, .frame, .nbits,
    .line(serial_in), .busy(far_busy));

  // System clock, 4 ns period.
  initial forever #2 mclk = ~mclk;

  // bit clocks at a tick every four cycles; disables driven at random each cycle.
  always @(posedge mclk) begin
    tick_cnt <= tick_cnt + 2'h1;
    rx_clk16 <= tick_cnt[1];
    tx_clk16 <= tick_cnt[0] ^ tick_cnt[1];
    flag_output_disable <= 1'($urandom);
    rx_bus_disable <= 1'($urandom);
  end

  // Data mask and frame bits for a format.
  function automatic logic [7:0] msk(input auart_ctrl_type f);
    return 8'hFF >> (2'h3 - {f.length_sel_hi, f.length_sel_lo});
  endfunction
  function automatic logic [3:0] nb(input auart_ctrl_type f);
    return 4'h7 + {f.length_sel_hi, f.length_sel_lo} + !f.parity_inhibit;
  endfunction
  function automatic logic [11:0] frm(input logic [7:0] v,
      input auart_ctrl_type f, input logic bp, input logic bs);
    int k;
    logic [11:0] r;
    r = 12'hFFE;
    for (k = 0; k < 5 + {f.length_sel_hi, f.length_sel_lo}; k++) r[k+1] = v[k];
    if (!f.parity_inhibit) r[k+1] = ^(v & msk(f)) ^ !f.parity_even_select ^ bp;
    r[nb(f)-1] = !bs;
    return r;
  endfunction

  task automatic chk(input logic [31:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic wrap_up;
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Avalon cycle: hold until waitrequest is seen low.
  task automatic av(input logic w, input logic [3:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic set_cfg(input auart_ctrl_type f, input logic av_path);
    if (av_path) av(1'b1, 4'h0, {27'h0, f}, q);
    else begin
      cfg_pins <= f;
      config_load <= 1'b1;
      @(posedge mclk) config_load <= 1'b0;
      @(posedge mclk);
    end
    cfg = f;
    av(1'b0, 4'h0, 32'h0, q);
    chk(q, {27'h0, f}, "control readback");
  endtask

  task automatic tx_one(input logic [7:0] v, input logic av_path);
    logic [11:0] f;
    int k, st;
    f = frm(v, cfg, 1'b0, 1'b0);
    st = !cfg.stop_count_select ? 16 : (msk(cfg) == 8'h1F ? 24 : 32);
    if (av_path) av(1'b1, 4'h4, {24'h0, v}, q);
    else begin
      tx_bus <= v;
      tx_hold_load_n <= 1'b0;
      repeat (2) @(posedge mclk);
      tx_hold_load_n <= 1'b1;
    end
    k = 0;
    while (serial_out !== 1'b0 && k < 300) begin @(posedge mclk); k++; end
    repeat (32) @(posedge mclk);
    chk(flags_o.tx_hold_empty, 1'b1, "hold not empty");
    for (k = 0; k < nb(cfg) - 1; k++) begin
      chk(serial_out, f[k], "tx bit");
      repeat (64) @(posedge mclk);
    end
    chk(serial_out, 1'b1, "tx stop level");
    repeat (st * 4 - 40) @(posedge mclk);
    chk({tx_shift_empty, serial_out}, 2'b01, "stop too short");
    repeat (24) @(posedge mclk);
    chk(tx_shift_empty, 1'b1, "shift not empty");
  endtask

  task automatic rx_one(input logic [7:0] v, input logic bp, bs, ov);
    frame <= frm(v, cfg, bp, bs);
    nbits <= nb(cfg);
    go <= 1'b1;
    @(posedge mclk) go <= 1'b0;
    repeat (4) @(posedge mclk);
    while (far_busy === 1'b1) @(posedge mclk);
    repeat (24) @(posedge mclk);
    chk(rx_bus_o, v & msk(cfg), "rx data");
    chk(flags_o.parity_fault, bp & !cfg.parity_inhibit, "parity");
    chk(flags_o.stop_fault, bs, "stop fault");
    chk(flags_o.rx_char_ready, 1'b1, "not ready");
    chk(flags_o.overrun_fault, ov, "overrun");
  endtask

  // Mode 1 bus write, taken at the strobe's trailing edge.
  task automatic mw(input logic [7:0] v, input logic cs);
    reg_select <= 1'b1;
    rd_not_wr <= 1'b0;
    {chip_sel_a, chip_sel_b, chip_sel_c} <= {1'b1, cs, 1'b1};
    tx_bus <= v;
    @(posedge mclk) bus_write_strobe <= 1'b1;
    repeat (2) @(posedge mclk);
    bus_write_strobe <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  // Main sequence.
  initial begin
    void'($urandom(77));
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    av(1'b0, 4'hC, 32'h0, q);
    chk(q, 32'h30, "status after reset");
    av(1'b0, 4'h2, 32'h0, q);
    chk(q, 32'h0, "unmapped read");
    for (i = 0; i < 8; i++) begin
      c = auart_ctrl_type'(5'($urandom));
      {c.stop_count_select, c.length_sel_hi, c.length_sel_lo} = 3'(i);
      c.parity_inhibit = i[0] ^ i[2];
      set_cfg(c, i[0]);
      tx_one(8'($urandom), i[1]);
      d = 8'($urandom);
      rx_one(d, i[1], 1'b0, 1'b0);
      if (i[0]) begin
        av(1'b0, 4'h8, 32'h0, q);
        chk(q, {24'h0, d & msk(cfg)}, "rx hold read");
      end else begin
        rx_ready_clear_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rx_ready_clear_n <= 1'b1;
        @(posedge mclk);
      end
      @(posedge mclk);
      chk(flags_o.rx_char_ready, 1'b0, "ready stuck");
    end
    rx_one(d, 1'b0, 1'b0, 1'b0);
    rx_one(~d, 1'b0, 1'b0, 1'b1);
    rx_one(d, 1'b1, 1'b1, 1'b1);
    repeat (800) @(posedge mclk);
    master_clear <= 1'b1;
    repeat (2) @(posedge mclk);
    master_clear <= 1'b0;
    @(posedge mclk);
    av(1'b0, 4'h0, 32'h0, q);
    chk(q, 32'h0, "control after clear");
    mode_sel <= 1'b1;
    c = auart_ctrl_type'(5'($urandom));
    mw({3'h0, c}, 1'b1);
    mw(~{3'h0, c}, 1'b0);
    av(1'b0, 4'h0, 32'h0, q);
    chk(q, {27'h0, c}, "bus control write");
    rd_not_wr <= 1'b1;
    chip_sel_b <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(rx_bus_o, 8'h30, "status on bus");
    chk(rx_bus_oe, !rx_bus_disable, "bus drive");
    wrap_up;
  end

  // Watchdog against a hung wait.
  initial begin
    repeat (40000) @(posedge mclk);
    fails++;
    wrap_up;
  end
endmodule
